// [rtl/ssp_pkg.sv]
// constants shared by the serial peripheral port design
package ssp_pkg;
  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  localparam logic [7:0] SSP_BUFFER_ADDR   = 8'hf7; // serial_port_buffer
  localparam logic [7:0] SSP_CONTROL_ADDR  = 8'he0; // serial_port_control
  localparam logic [7:0] SSP_BUFFER_RST    = 8'h00;
  localparam logic [7:0] SSP_CONTROL_RST   = 8'h00;
  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int SSP_BIT_DONE   = 7;
  localparam int SSP_BIT_WRITE_COLLISION_FLAG   = 6;
  localparam int SSP_BIT_ENABLE = 5;
  localparam int SSP_BIT_ROLE   = 4;
  localparam int SSP_BIT_CLOCK_IDLE_LEVEL   = 3;
  localparam int SSP_BIT_CLOCK_PHASE_SELECT   = 2;
  localparam int SSP_BIT_RATEHI = 1;
  localparam int SSP_BIT_RATELO = 0;
  // ----------------------------------------------------------------
  // transfer constants
  // ----------------------------------------------------------------
  localparam int SSP_BITS_PER_BYTE = 8;
  localparam logic [3:0] SSP_LAST_BIT = 4'h7;
  localparam int SSP_BUF_DEPTH = 2;
  typedef enum logic [1:0] {
    SSP_IDLE  = 2'b00,
    SSP_FIRST = 2'b01,
    SSP_SECND = 2'b10
  } ssp_state_t;
endpackage

// [rtl/ssp_rx_buf.sv]
// two-entry buffer for received bytes, registered read data
`timescale 1ns/1ps
module ssp_rx_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;
  // ----------------------------------------------------------------
  // flags and pointers
  // ----------------------------------------------------------------
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)  rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // storage cleared at reset so the buffer reads as zero, not unknown, until bytes are written
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
    end else if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  // read data held in a register, showing the head entry
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_data <= '0;
    end else begin
      out_data <= mem_r[rp_r];
    end
  end
endmodule // ssp_rx_buf

// [rtl/ssp_port.sv]
// byte-wide full-duplex serial peripheral port, master or slave role
`timescale 1ns/1ps
module ssp_port
  import ssp_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // register access port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // serial pins
  input  wire logic       sclk_in,
  output logic            sclk_out,
  output logic            sclk_oe,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic       slave_select_n,
  // status toward the core
  output logic            irq_req,
  output logic            spi_owns_pins
);
  ssp_state_t st_r;
  logic [5:0] ctl_r;            // enable, role, clock_idle_level, clock_phase_select, rate
  logic       done_r;
  logic       write_collision_flag_r;
  logic [7:0] tx_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic [3:0] div_r;
  logic       sck_r;
  logic       busy_r;
  logic       in_r;             // last sampled data bit, waits for the shift edge
  logic       smp_pend_r;       // master: data pin is sampled in this cycle
  logic       fin_r;            // master phase 1: last bit still to be shifted in
  logic       smp_bit;
  logic       sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic       ss_s1_r, ss_s2_r, ss_s3_r;
  logic       byte_end;
  logic       rx_ready;
  logic       buf_valid;
  logic [7:0] buf_data;
  logic       buf_pop;
  logic [3:0] div_max;
  logic       en, master, clock_idle_level, clock_phase_select;
  logic       wr_buf, rd_buf, wr_ctl;
  logic       s_lead, s_trail, s_ss_rise, s_ss_fall, s_active;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign en     = ctl_r[SSP_BIT_ENABLE];
  assign master = ctl_r[SSP_BIT_ROLE];
  assign clock_idle_level   = ctl_r[SSP_BIT_CLOCK_IDLE_LEVEL];
  assign clock_phase_select   = ctl_r[SSP_BIT_CLOCK_PHASE_SELECT];
  assign wr_buf = reg_wr && (reg_addr == SSP_BUFFER_ADDR);
  assign rd_buf = reg_rd && (reg_addr == SSP_BUFFER_ADDR);
  assign wr_ctl = reg_wr && (reg_addr == SSP_CONTROL_ADDR);
  // the pin edge lags the decision by one cycle, so the sample is taken then
  assign smp_bit = smp_pend_r ? miso_in : in_r;
  // half-period length: rate 0..3 gives divide by 2,4,8,16
  always_comb begin
    case (ctl_r[SSP_BIT_RATEHI:SSP_BIT_RATELO])
      2'b00:   div_max = 4'h0;
      2'b01:   div_max = 4'h1;
      2'b10:   div_max = 4'h3;
      2'b11:   div_max = 4'h7;
      default: div_max = 4'h0;
    endcase
  end
  // ----------------------------------------------------------------
  // slave pin synchronisers
  // ----------------------------------------------------------------
  // third stage only feeds the edge detector, never the first stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      ss_s1_r   <= 1'b1;
      ss_s2_r   <= 1'b1;
      ss_s3_r   <= 1'b1;
    end else begin
      sclk_s1_r <= sclk_in;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      ss_s1_r   <= slave_select_n;
      ss_s2_r   <= ss_s1_r;
      ss_s3_r   <= ss_s2_r;
    end
  end
  // leading edge leaves the idle level, trailing edge returns to it
  assign s_active  = !master && en && !ss_s2_r;
  assign s_lead    = s_active && (sclk_s2_r != sclk_s3_r) && (sclk_s3_r == clock_idle_level);
  assign s_trail   = s_active && (sclk_s2_r != sclk_s3_r) && (sclk_s2_r == clock_idle_level);
  assign s_ss_fall = !master && en && ss_s3_r && !ss_s2_r;
  assign s_ss_rise = !master && en && !ss_s3_r && ss_s2_r;
  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  // the master runs a small state machine; the slave follows its clock
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r     <= SSP_IDLE;
      sh_r     <= 8'h00;
      bit_r    <= 4'h0;
      div_r    <= 4'h0;
      sck_r    <= 1'b0;
      busy_r   <= 1'b0;
      byte_end <= 1'b0;
      in_r       <= 1'b0;
      smp_pend_r <= 1'b0;
      fin_r      <= 1'b0;
    end else begin
      byte_end   <= 1'b0;
      smp_pend_r <= 1'b0;
      if (!en) begin
        st_r   <= SSP_IDLE;
        busy_r <= 1'b0;
        bit_r  <= 4'h0;
        sck_r  <= clock_idle_level;
        fin_r  <= 1'b0;
      end else if (master) begin
        // data pin is read when the clock pin really moves, not at the decision
        if (smp_pend_r) in_r <= miso_in;
        case (st_r)
          SSP_IDLE: begin
            sck_r <= clock_idle_level;
            if (fin_r) begin
              // phase 1: the last trailing sample completes the byte
              sh_r     <= {sh_r[6:0], miso_in};
              fin_r    <= 1'b0;
              busy_r   <= 1'b0;
              byte_end <= 1'b1;
            end else if (wr_buf && rx_ready && !busy_r) begin
              sh_r   <= reg_wdata;
              bit_r  <= 4'h0;
              div_r  <= 4'h0;
              busy_r <= 1'b1;
              st_r   <= SSP_FIRST;
            end
          end
          SSP_FIRST: begin
            // leading edge: phase 1 shifts here, phase 0 samples here
            if (div_r == div_max) begin
              div_r <= 4'h0;
              sck_r <= !clock_idle_level;
              if (clock_phase_select) begin
                if (bit_r != 4'h0) sh_r <= {sh_r[6:0], smp_bit};
              end else begin
                smp_pend_r <= 1'b1;
              end
              st_r <= SSP_SECND;
            end else begin
              div_r <= div_r + 4'h1;
            end
          end
          SSP_SECND: begin
            // trailing edge: phase 0 shifts here, phase 1 samples here
            if (div_r == div_max) begin
              div_r <= 4'h0;
              sck_r <= clock_idle_level;
              if (clock_phase_select) smp_pend_r <= 1'b1;
              else sh_r <= {sh_r[6:0], smp_bit};
              if (bit_r == SSP_LAST_BIT) begin
                st_r <= SSP_IDLE;
                if (clock_phase_select) begin
                  fin_r <= 1'b1;
                end else begin
                  busy_r   <= 1'b0;
                  byte_end <= 1'b1;
                end
              end else begin
                bit_r <= bit_r + 4'h1;
                st_r  <= SSP_FIRST;
              end
            end else begin
              div_r <= div_r + 4'h1;
            end
          end
          default: st_r <= SSP_IDLE;
        endcase
      end else begin
        st_r  <= SSP_IDLE;
        fin_r <= 1'b0;
        if (wr_buf && !busy_r) sh_r <= reg_wdata;
        if (s_ss_fall) bit_r <= 4'h0;
        if (s_lead || s_trail) busy_r <= 1'b1;
        // shift edge: trailing for phase 0, leading after the first bit for phase 1
        if ((s_trail && !clock_phase_select) || (s_lead && clock_phase_select && bit_r != 4'h0)) begin
          sh_r <= {sh_r[6:0], in_r};
        end
        // sample edge: leading for phase 0, trailing for phase 1
        if ((s_lead && !clock_phase_select) || (s_trail && clock_phase_select)) begin
          in_r  <= mosi_in;
          bit_r <= bit_r + 4'h1;
          if (clock_phase_select && bit_r == SSP_LAST_BIT) begin
            sh_r     <= {sh_r[6:0], mosi_in};
            byte_end <= 1'b1;
            busy_r   <= 1'b0;
            bit_r    <= 4'h0;
          end
        end
        if (!clock_phase_select && s_ss_rise && bit_r == 4'(SSP_BITS_PER_BYTE)) begin
          byte_end <= 1'b1;
          busy_r   <= 1'b0;
        end
        if (s_ss_rise && !clock_phase_select) bit_r <= 4'h0;
      end
    end
  end
  // ----------------------------------------------------------------
  // received bytes buffer
  // ----------------------------------------------------------------
  // a new master transfer is held off while both entries are full
  assign buf_pop = rd_buf && buf_valid;
  ssp_rx_buf #(.WIDTH(8), .DEPTH(SSP_BUF_DEPTH)) u_rx_buf (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (byte_end),
    .in_data   (sh_r),
    .in_ready  (rx_ready),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );
  // ----------------------------------------------------------------
  // control register and flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_r  <= SSP_CONTROL_RST[5:0];
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
    end else begin
      if (wr_ctl) ctl_r <= reg_wdata[5:0];
      // hardware set wins over any clear in the same cycle
      if (byte_end) done_r <= 1'b1;
      else if (rd_buf || (wr_ctl && !reg_wdata[SSP_BIT_DONE])) done_r <= 1'b0;
      if (wr_buf && busy_r) write_collision_flag_r <= 1'b1;
      else if (wr_ctl && !reg_wdata[SSP_BIT_WRITE_COLLISION_FLAG]) write_collision_flag_r <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata     <= 8'h00;
      sclk_out      <= 1'b0;
      sclk_oe       <= 1'b0;
      mosi_out      <= 1'b0;
      mosi_oe       <= 1'b0;
      miso_out      <= 1'b0;
      miso_oe       <= 1'b0;
      irq_req       <= 1'b0;
      spi_owns_pins <= 1'b0;
    end else begin
      if (reg_rd && reg_addr == SSP_BUFFER_ADDR) begin
        reg_rdata <= buf_data;
      end else if (reg_rd && reg_addr == SSP_CONTROL_ADDR) begin
        reg_rdata <= {done_r, write_collision_flag_r, ctl_r[5:1],
                      master ? ctl_r[SSP_BIT_RATELO] : ss_s2_r};
      end else if (reg_rd) begin
        reg_rdata <= 8'h00;
      end
      sclk_out      <= sck_r;
      sclk_oe       <= en && master;
      mosi_out      <= sh_r[7];
      mosi_oe       <= en && master;
      miso_out      <= sh_r[7];
      miso_oe       <= en && !master && !ss_s2_r;
      irq_req       <= done_r;
      spi_owns_pins <= en;
    end
  end
endmodule // ssp_port

// [verification/ssp_far_slave.sv]
// behavioural serial slave facing the port in master role
`timescale 1ns/1ps
module ssp_far_slave (
  // serial lines
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  // mode and captured byte
  input  wire logic       clock_idle_level,
  input  wire logic       clock_phase_select,
  output logic [7:0]      rx
);
  logic [7:0] sh = 8'h00;
  initial rx = 8'h00;
  initial miso = 1'b1;
  // preload the reply; leading-edge shifting shows the inverse until the first edge
  task automatic load(input logic [7:0] d);
    sh = d;
    rx = 8'h00;
    miso = clock_phase_select ? ~d[7] : d[7];
  endtask
  // shift on one edge, sample on the other, msb first
  always @(sclk) begin
    if ((sclk != clock_idle_level) == clock_phase_select) begin
      if (!clock_phase_select) sh = {sh[6:0], 1'b0};
      miso = sh[7];
      if (clock_phase_select) sh = {sh[6:0], 1'b0};
    end else rx = {rx[6:0], mosi};
  end
endmodule // ssp_far_slave

// [verification/ssp_port_assertions.sv]
// concurrent checks on the serial peripheral port pins
`timescale 1ns/1ps
module ssp_port_chk
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // pins and status
  input wire logic       sclk_out,
  input wire logic       sclk_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       slave_select_n,
  input wire logic       irq_req,
  input wire logic       spi_owns_pins
);
  logic       cw;
  logic [2:0] cwd;
  logic [3:0] sh;
  logic [5:0] hc, ec;
  assign cw = reg_wr && reg_addr == SSP_CONTROL_ADDR;
  // shadow of enable, polarity and rate; the clock pin lags a write by three samples
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) cwd <= 3'b000;
    else cwd <= {cwd[1:0], cw};
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) sh <= 4'h0;
    else if (cw) sh <= {reg_wdata[5], reg_wdata[3], reg_wdata[1:0]};
  end
  // cycles since the clock pin last moved, saturating
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) hc <= 6'h00;
    else if ($changed(sclk_out)) hc <= 6'h00;
    else if (hc != 6'h3f) hc <= hc + 6'h01;
  end
  // clock edges in the current burst; config writes may move the idle level
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) ec <= 6'h00;
    else if ($rose(irq_req) || cw || cwd != 3'b000) ec <= 6'h00;
    else if (sclk_oe && $changed(sclk_out)) ec <= ec + 6'h01;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_rdata_unmapped: assert property (
    reg_rd && reg_addr != SSP_BUFFER_ADDR && reg_addr != SSP_CONTROL_ADDR |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_pins_enable: assert property (cwd[1] |-> spi_owns_pins == sh[3])
    else $error("pin ownership differs from enable");
  a_role_pins: assert property (sclk_oe |-> mosi_oe && !miso_oe)
    else $error("master drives wrong pins");
  a_sclk_rate: assert property (
    sclk_oe && $changed(sclk_out) && ec != 6'h00 |-> hc >= (6'h01 << sh[1:0]) - 6'h01)
    else $error("serial clock half period too short");
  a_sclk_idle: assert property (
    sclk_oe && hc == 6'h3f && cwd == 3'b000 |-> sclk_out == sh[2])
    else $error("serial clock idle level wrong");
  a_burst_eight: assert property ($rose(irq_req) && sclk_oe |-> ec == 6'h10)
    else $error("burst not sixteen clock edges");
  a_done_read_clr: assert property (
    reg_rd && reg_addr == SSP_BUFFER_ADDR && irq_req |-> ##[1:3] !irq_req)
    else $error("buffer read left done flag set");
  a_select_gate: assert property (slave_select_n [*5] |-> !miso_oe)
    else $error("slave drives data while deselected");
endmodule // ssp_port_chk
bind ssp_port ssp_port_chk u_chk (.sys_clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .sclk_out, .sclk_oe, .mosi_oe, .miso_oe, .slave_select_n, .irq_req,
  .spi_owns_pins);

// [verification/ssp_port_bench.sv]
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module ssp_port_bench;
  import ssp_pkg::*;
  logic       sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, far_rx, got, cfg = 8'h00;
  logic       sclk_in = 1'b0, mosi_in = 1'b0, ss_n = 1'b1, far_miso;
  logic       sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq_req, spi_owns_pins;
  logic [7:0] tx [4] = '{8'ha5, 8'h3c, 8'h81, 8'h7e};
  int         miscompares = 0, checked = 0;
  always #2 sys_clk = ~sys_clk;
  ssp_port i_dut (.sys_clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .sclk_in, .sclk_out, .sclk_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in(far_miso),
    .miso_out, .miso_oe, .slave_select_n(ss_n), .irq_req, .spi_owns_pins);
  ssp_far_slave i_far (.sclk(sclk_out), .mosi(mosi_out), .miso(far_miso), .clock_idle_level(cfg[3]),
    .clock_phase_select(cfg[2]), .rx(far_rx));
  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // strobes rise just after an edge and stay for exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    chk(n, reg_rdata, e);
  endtask
  // bounded wait for the done level
  task automatic wait_irq;
    for (int k = 0; k < 600 && irq_req !== 1'b1; k++) @(posedge sys_clk);
    if (irq_req !== 1'b1) begin
      chk("irq_req", {7'h00, irq_req}, 8'h01);
      close_out();
    end
  endtask
  // external master, half period six cycles; phase 0 sets data before the leading edge
  task automatic sl_xfer(input logic ph, input logic [7:0] m, output logic [7:0] q);
    for (int b = 7; b >= 0; b--) begin
      mosi_in = m[b];
      if (!ph) begin
        repeat (6) @(posedge sys_clk);
        #1;
        q[b] = miso_out;
      end
      sclk_in = 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      if (ph) q[b] = miso_out;
      sclk_in = 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rstn = 1'b1;
    rc("buffer reset", SSP_BUFFER_ADDR, SSP_BUFFER_RST);
    rc("unmapped", 8'h00, 8'h00);
    $display("test reset done");
    // every polarity, phase and rate; select stays high to show master ignores it
    for (int i = 0; i < 4; i++) begin
      cfg = {4'h3, i[1:0], i[1:0]};
      wr(SSP_CONTROL_ADDR, cfg);
      // let a new idle level reach the pin before the far side is armed
      repeat (3) @(posedge sys_clk);
      i_far.load(~tx[i]);
      wr(SSP_BUFFER_ADDR, tx[i]);
      if (i == 0) wr(SSP_BUFFER_ADDR, 8'h00);
      wait_irq();
      chk("pins", {7'h00, spi_owns_pins}, 8'h01);
      rc("flags", SSP_CONTROL_ADDR, cfg | 8'h80 | (i == 0 ? 8'h40 : 8'h00));
      if (i == 0) wr(SSP_CONTROL_ADDR, cfg);
      rc("master rx", SSP_BUFFER_ADDR, ~tx[i]);
      chk("far rx", far_rx, tx[i]);
      rc("flags clear", SSP_CONTROL_ADDR, cfg);
      $display("test master mode %0d done", i);
    end
    // slave role, phase 1, half period of six cycles for the synchronisers
    wr(SSP_CONTROL_ADDR, 8'h24);
    rc("select high", SSP_CONTROL_ADDR, 8'h25);
    ss_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    rc("select low", SSP_CONTROL_ADDR, 8'h24);
    wr(SSP_BUFFER_ADDR, 8'hc6);
    sl_xfer(1'b1, 8'h55, got);
    wait_irq();
    rc("slave rx", SSP_BUFFER_ADDR, 8'h55);
    chk("slave tx", got, 8'hc6);
    ss_n = 1'b1;
    // phase 0: select framed around the byte, which ends when select rises
    wr(SSP_CONTROL_ADDR, 8'h20);
    wr(SSP_BUFFER_ADDR, 8'h5a);
    ss_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    sl_xfer(1'b0, 8'h3c, got);
    ss_n = 1'b1;
    wait_irq();
    rc("slave rx ph0", SSP_BUFFER_ADDR, 8'h3c);
    chk("slave tx ph0", got, 8'h5a);
    $display("test slave mode done");
    close_out();
  end
endmodule // ssp_port_bench
